// ==== pkg/ofc_map.vh ====
`ifndef OFC_MAP_VH
`define OFC_MAP_VH
// apb register byte offsets
`define OFC_CTRL_ADDR 12'h000
`define OFC_CLKSEL_ADDR 12'h004
`define OFC_STAT_ADDR 12'h008
`define OFC_FLAG_ADDR 12'h00C
`define OFC_DCO_ADDR 12'h010
// control register fields
`define OFC_CTRL_MAIN_OFF 0
`define OFC_CTRL_PERI_OFF 1
`define OFC_CTRL_BIAS_OFF 2
`define OFC_CTRL_LF_STOP 3
`define OFC_CTRL_XT2_OFF 4
`define OFC_CTRL_XTS 5
`define OFC_CTRL_IRQ_EN 6
// clock select fields
`define OFC_MAIN_CLOCK_SOURCE_SELECT_LO 0
`define OFC_MAIN_CLOCK_SOURCE_SELECT_HI 1
`define OFC_SUB_CLOCK_SOURCE_SELECT_BIT 2
// main and sub source select codes
`define OFC_MAIN_CLOCK_SOURCE_SELECT_XT2 2'h2
`define OFC_MAIN_CLOCK_SOURCE_SELECT_XT1 2'h3
`define OFC_SUB_CLOCK_SOURCE_SELECT_XT 1'h1
`define OFC_SUB_CLOCK_SOURCE_SELECT_DCO 1'h0
// flag register fields
`define OFC_FLAG_BIT 0
// rc oscillator setting fields and reset values
`define OFC_RSEL_LO 0
`define OFC_RSEL_HI 2
`define OFC_DCO_LO 4
`define OFC_DCO_HI 6
`define OFC_MOD_LO 8
`define OFC_MOD_HI 12
`define OFC_RSEL_RST 3'h4
`define OFC_DCO_RST 3'h3
`define OFC_MOD_RST 5'h00
// fault timing: 100 cycles at 1 MHz reference
`define OFC_REF_HZ 1000000
`define OFC_CLK_HZ 125000000
`define OFC_MISS_CYC 100
`define OFC_CNT_W 7
`define OFC_PRE_W 7
`endif

// ==== logic/ofc_osc_fault_ctrl.v ====
// Decided for this implementation: the register addresses and register access over APB.
`include "ofc_map.vh"
module ofc_osc_fault_ctrl
#(
   parameter THREE_OSC = 1
)
(
   input wire clk_i,
   input wire sys_rst_i,
   input wire por_i,
   input wire rst_pin_i,
   input wire wdt_expire_i,
   input wire wdt_key_viol_i,
   input wire xt1_clk_i,
   input wire xt2_clk_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   output wire [31:0] prdata_o,
   output wire pready_o,
   output wire pslverr_o,
   output reg xt1_enable_o,
   output reg xt1_hf_mode_o,
   output reg xt1_fast_start_o,
   output reg xt2_enable_o,
   output reg xt2_fast_start_o,
   output reg rc_osc_on_o,
   output reg rc_bias_on_o,
   output reg nmi_req_o,
   output reg power_up_clear_o
);
   // ************************************************************
   // reference tick and helpers
   // ************************************************************
   // divider end value, cut to the counter width on purpose
   localparam integer PRE_DIV = `OFC_CLK_HZ / `OFC_REF_HZ - 1;
   localparam [`OFC_PRE_W-1:0] PRE_MAX = PRE_DIV[`OFC_PRE_W-1:0];
   // missed-cycle threshold at the counter width
   localparam integer MISS_INT = `OFC_MISS_CYC;
   localparam [`OFC_CNT_W-1:0] MISS_MAX = MISS_INT[`OFC_CNT_W-1:0];
   reg [`OFC_PRE_W-1:0] pre_cnt; // divider to 1 MHz
   reg ref_tick; // one-cycle reference pulse
   // sampled-edge check: 2nd and 3rd flops agree on a change
   function edge_seen;
      input [2:0] s;
      input last;
      begin
         edge_seen = (s[1] == s[2]) && (s[2] != last);
      end
   endfunction
   // next fault-counter value
   // saturates at the threshold so it never wraps
   function [`OFC_CNT_W-1:0] cnt_step;
      input [`OFC_CNT_W-1:0] c;
      input fault;
      begin
         if (c < MISS_MAX)
            cnt_step = c + 1'b1;
         else
            cnt_step = c;
      end
   endfunction
   // reference prescaler
   always @(posedge clk_i)
   begin
      if (sys_rst_i || pre_cnt == PRE_MAX)
      begin
         pre_cnt <= {`OFC_PRE_W{1'b0}};
         ref_tick <= ~sys_rst_i;
      end
      else
      begin
         pre_cnt <= pre_cnt + 1'b1;
         ref_tick <= 1'b0;
      end
   end
   // ************************************************************
   // power-up clear generation
   // ************************************************************
   reg [2:0] pin_sync; // reset pin synchroniser
   reg pin_rst; // agreed reset pin level
   // three-flop sampler; the level moves only when
   // the second and third flops agree, so a glitch
   // caught by one flop never raises a clear
   always @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         pin_sync <= 3'h0;
         pin_rst <= 1'b0;
      end
      else
      begin
         pin_sync <= {pin_sync[1:0], rst_pin_i};
         // agreed samples update the level
         if (pin_sync[1] == pin_sync[2])
            pin_rst <= pin_sync[2];
      end
   end
   always @(posedge clk_i)
   begin
      if (sys_rst_i)
         power_up_clear_o <= 1'b1;
      else
         power_up_clear_o <= por_i | pin_rst | wdt_expire_i | wdt_key_viol_i;
   end
   // ************************************************************
   // apb registers
   // ************************************************************
   reg [6:0] ctrl; // status-register style control bits
   reg [2:0] clksel; // sub_clock_source_select and main_clock_source_select
   reg [2:0] rsel; // bias resistor select
   reg [2:0] dco_step; // rc frequency step
   reg [4:0] mod_cnt; // fractional step count
   reg osc_flag; // sticky oscillator fault flag
   reg xt1_fault; // first crystal fault
   reg xt2_fault; // second crystal fault
   reg [31:0] rdata; // read data flop
   wire wr = psel_i & penable_i & pwrite_i;
   wire rd_setup = psel_i & ~penable_i & ~pwrite_i;
   wire main_off = ctrl[`OFC_CTRL_MAIN_OFF];
   wire peri_off = ctrl[`OFC_CTRL_PERI_OFF];
   wire [1:0] main_clock_source_select = clksel[`OFC_MAIN_CLOCK_SOURCE_SELECT_HI:`OFC_MAIN_CLOCK_SOURCE_SELECT_LO];
   wire sub_clock_source_select = clksel[`OFC_SUB_CLOCK_SOURCE_SELECT_BIT];
   wire addr_ok = (paddr_i == `OFC_CTRL_ADDR) || (paddr_i == `OFC_CLKSEL_ADDR) ||
      (paddr_i == `OFC_STAT_ADDR) || (paddr_i == `OFC_FLAG_ADDR) ||
      (paddr_i == `OFC_DCO_ADDR);
   // no wait states: every access ends at its first access edge
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~addr_ok;
   assign prdata_o = rdata;
   // clear permitted only with faults low
   // a refused clear leaves no trace; software must retry
   wire clr_ok = THREE_OSC ? ~(xt1_fault | xt2_fault) : ~xt1_fault;
   wire flag_clr = wr && paddr_i == `OFC_FLAG_ADDR && pwdata_i[`OFC_FLAG_BIT] && clr_ok;
   // control and select registers
   always @(posedge clk_i)
   begin
      if (sys_rst_i || power_up_clear_o)
      begin
         // all bits zero but XTS, which a power-up clear keeps: main clock from rc
         ctrl <= 7'h00;
         if (!sys_rst_i)
            ctrl[`OFC_CTRL_XTS] <= ctrl[`OFC_CTRL_XTS];
         clksel <= 3'h0;
         rsel <= `OFC_RSEL_RST;
         dco_step <= `OFC_DCO_RST;
         mod_cnt <= `OFC_MOD_RST;
      end
      else if (wr)
      begin
         case (paddr_i)
            `OFC_CTRL_ADDR: ctrl <= pwdata_i[6:0];
            `OFC_CLKSEL_ADDR: clksel <= pwdata_i[2:0];
            `OFC_DCO_ADDR:
            begin
               rsel <= pwdata_i[`OFC_RSEL_HI:`OFC_RSEL_LO];
               dco_step <= pwdata_i[`OFC_DCO_HI:`OFC_DCO_LO];
               mod_cnt <= pwdata_i[`OFC_MOD_HI:`OFC_MOD_LO];
            end
            default: ctrl <= ctrl;
         endcase
      end
   end
   // fault flag: set wins over clear
   // comes up set, as both faults are active at power-up
   always @(posedge clk_i)
   begin
      if (sys_rst_i)
         osc_flag <= 1'b1;
      else if (xt1_fault || (THREE_OSC != 0 && xt2_fault))
         osc_flag <= 1'b1;
      else if (flag_clr)
         osc_flag <= 1'b0;
   end
   // read mux, data captured in setup phase
   always @(posedge clk_i)
   begin
      if (sys_rst_i)
         rdata <= 32'h0000_0000;
      else if (rd_setup)
      begin
         case (paddr_i)
            `OFC_CTRL_ADDR: rdata <= {25'h0, ctrl};
            `OFC_CLKSEL_ADDR: rdata <= {29'h0, clksel};
            `OFC_STAT_ADDR: rdata <= {24'h0, rc_bias_on_o, rc_osc_on_o, xt2_enable_o,
               xt1_enable_o, xt2_fault, xt1_fault, nmi_req_o, osc_flag};
            `OFC_FLAG_ADDR: rdata <= {31'h0, osc_flag};
            `OFC_DCO_ADDR: rdata <= {19'h0, mod_cnt, 1'b0, dco_step, 1'b0, rsel};
            default: rdata <= 32'h0000_0000;
         endcase
      end
   end
   // ************************************************************
   // crystal fault detection
   // ************************************************************
   reg [2:0] xt1_sync; // first crystal sampler
   reg [2:0] xt2_sync; // second crystal sampler
   reg xt1_last; // last agreed level
   reg xt2_last;
   reg xt1_seen; // edge since last tick
   reg xt2_seen;
   reg [`OFC_CNT_W-1:0] xt1_miss; // missed reference cycles
   reg [`OFC_CNT_W-1:0] xt2_miss;
   reg [`OFC_CNT_W-1:0] xt1_good; // good reference cycles
   reg [`OFC_CNT_W-1:0] xt2_good;
   // both crystals share one process so their counters
   // advance on the same reference tick; an edge landing
   // on the tick cycle itself is dropped, which is harmless
   always @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         xt1_sync <= 3'h0;
         xt2_sync <= 3'h0;
         xt1_last <= 1'b0;
         xt2_last <= 1'b0;
         xt1_seen <= 1'b0;
         xt2_seen <= 1'b0;
         xt1_miss <= {`OFC_CNT_W{1'b0}};
         xt2_miss <= {`OFC_CNT_W{1'b0}};
         xt1_good <= {`OFC_CNT_W{1'b0}};
         xt2_good <= {`OFC_CNT_W{1'b0}};
         xt1_fault <= 1'b1;
         xt2_fault <= 1'b1;
      end
      else
      begin
         xt1_sync <= {xt1_sync[1:0], xt1_clk_i};
         xt2_sync <= {xt2_sync[1:0], xt2_clk_i};
         if (xt1_sync[1] == xt1_sync[2])
            xt1_last <= xt1_sync[2];
         if (xt2_sync[1] == xt2_sync[2])
            xt2_last <= xt2_sync[2];
         if (ref_tick)
         begin
            // count missed or good reference cycles
            xt1_seen <= 1'b0;
            xt2_seen <= 1'b0;
            xt1_miss <= xt1_seen ? {`OFC_CNT_W{1'b0}} : cnt_step(xt1_miss, xt1_fault);
            xt2_miss <= xt2_seen ? {`OFC_CNT_W{1'b0}} : cnt_step(xt2_miss, xt2_fault);
            xt1_good <= xt1_seen ? cnt_step(xt1_good, xt1_fault) : {`OFC_CNT_W{1'b0}};
            xt2_good <= xt2_seen ? cnt_step(xt2_good, xt2_fault) : {`OFC_CNT_W{1'b0}};
            if (~xt1_seen && xt1_miss + 1'b1 >= MISS_MAX)
               xt1_fault <= 1'b1;
            else if (xt1_seen && xt1_good + 1'b1 >= MISS_MAX)
               xt1_fault <= 1'b0;
            if (~xt2_seen && xt2_miss + 1'b1 >= MISS_MAX)
               xt2_fault <= 1'b1;
            else if (xt2_seen && xt2_good + 1'b1 >= MISS_MAX)
               xt2_fault <= 1'b0;
         end
         else
         begin
            if (edge_seen(xt1_sync, xt1_last))
               xt1_seen <= 1'b1;
            if (edge_seen(xt2_sync, xt2_last))
               xt2_seen <= 1'b1;
         end
      end
   end
   // ************************************************************
   // oscillator and rc enables
   // ************************************************************
   // crystal clock usage by main and peripheral clocks
   wire main_uses_xt2 = ~main_off && main_clock_source_select == `OFC_MAIN_CLOCK_SOURCE_SELECT_XT2;
   wire peri_uses_xt2 = ~peri_off && sub_clock_source_select == `OFC_SUB_CLOCK_SOURCE_SELECT_XT;
   wire main_uses_xt1 = ~main_off && (main_clock_source_select == `OFC_MAIN_CLOCK_SOURCE_SELECT_XT1 ||
      (THREE_OSC == 0 && main_clock_source_select == `OFC_MAIN_CLOCK_SOURCE_SELECT_XT2));
   wire peri_uses_xt1 = THREE_OSC == 0 && peri_uses_xt2;
   // rc clock needed by main or peripheral clock
   wire rc_needed = (~main_off && ~main_clock_source_select[1]) || (~peri_off && sub_clock_source_select == `OFC_SUB_CLOCK_SOURCE_SELECT_DCO);
   always @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         xt1_enable_o <= 1'b0;
         xt1_hf_mode_o <= 1'b0;
         xt1_fast_start_o <= 1'b0;
         xt2_enable_o <= 1'b0;
         xt2_fast_start_o <= 1'b0;
         rc_osc_on_o <= 1'b1;
         rc_bias_on_o <= 1'b1;
         nmi_req_o <= 1'b0;
      end
      else
      begin
         xt1_hf_mode_o <= ctrl[`OFC_CTRL_XTS];
         // among resets, hf crystal halted only by por or pin reset
         // stop bit ignored while used, in either mode
         xt1_enable_o <= (~ctrl[`OFC_CTRL_XTS] | ~(por_i | pin_rst)) &
            (~ctrl[`OFC_CTRL_LF_STOP] | main_uses_xt1 | peri_uses_xt1);
         // second crystal off only when unused
         // a used crystal keeps running whatever the off bit says
         xt2_enable_o <= ~ctrl[`OFC_CTRL_XT2_OFF] | main_uses_xt2 | peri_uses_xt2;
         xt1_fast_start_o <= xt1_fault;
         xt2_fast_start_o <= xt2_fault;
         nmi_req_o <= osc_flag & ctrl[`OFC_CTRL_IRQ_EN];
         rc_osc_on_o <= rc_needed;
         // bias off honoured only when unused
         rc_bias_on_o <= rc_needed | ~ctrl[`OFC_CTRL_BIAS_OFF];
      end
   end
endmodule

// ==== verification/ofc_props.sv ====
`include "ofc_map.vh"
module ofc_props
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic por_i,
   input wire logic rst_pin_i,
   input wire logic wdt_expire_i,
   input wire logic wdt_key_viol_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic pready_o,
   input wire logic xt1_enable_o,
   input wire logic xt1_hf_mode_o,
   input wire logic xt2_enable_o,
   input wire logic rc_osc_on_o,
   input wire logic rc_bias_on_o,
   input wire logic power_up_clear_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // shadow copies of control and select bits
   logic [6:0] ctl;
   logic [2:0] sel;
   wire inrst = sys_rst_i || power_up_clear_o;
   wire wr = psel_i && penable_i && pwrite_i && pready_o;
   always_ff @(posedge clk_i)
   begin
      if (inrst)
      begin
         // crystal mode bit survives a power-up clear; only sys_rst_i zeroes it
         ctl <= {1'b0, ctl[5] && !sys_rst_i, 5'h00};
         sel <= 3'h0;
      end
      else if (wr && paddr_i == `OFC_CTRL_ADDR)
         ctl <= pwdata_i[6:0];
      else if (wr && paddr_i == `OFC_CLKSEL_ADDR)
         sel <= pwdata_i[2:0];
   end
   // which clock sources are in use
   wire rcneed = (!ctl[0] && !sel[1]) || (!ctl[1] && !sel[2]);
   wire x2use = (!ctl[0] && sel[1:0] == 2'h2) || (!ctl[1] && sel[2]);
   wire x1use = !ctl[0] && sel[1:0] == 2'h3;
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (inrst);
   // three samples cover the register to output lag
   sequence held(c);
      c [*3];
   endsequence
   property steady(c, o);
      held(c) |-> o;
   endproperty
   rc_forced_a: assert property (steady(rcneed, rc_osc_on_o && rc_bias_on_o))
      else $error("rc clock or bias off while needed");
   rc_off_a: assert property (steady(!rcneed, !rc_osc_on_o))
      else $error("rc clock on while unused");
   bias_keep_a: assert property (steady(!rcneed && !ctl[2], rc_bias_on_o))
      else $error("bias off without off bit");
   bias_off_a: assert property (steady(!rcneed && ctl[2], !rc_bias_on_o))
      else $error("bias on despite off bit");
   xt2_stop_a: assert property (steady(ctl[4] && !x2use, !xt2_enable_o))
      else $error("second crystal not stopped");
   xt2_run_a: assert property (steady(!ctl[4] || x2use, xt2_enable_o))
      else $error("second crystal stopped while needed");
   xt1_stop_a: assert property (steady(ctl[3] && !x1use, !xt1_enable_o))
      else $error("first crystal not stopped");
   xt1_run_a: assert property (steady(!ctl[3] || x1use, xt1_enable_o))
      else $error("first crystal stopped while needed");
   hf_mode_a: assert property (steady(ctl[5], xt1_hf_mode_o))
      else $error("high frequency mode not selected");
   puc_gen_a: assert property (disable iff (sys_rst_i)
      por_i || wdt_expire_i || wdt_key_viol_i |=> power_up_clear_o)
      else $error("no power up clear after event");
   por_halt_a: assert property (disable iff (sys_rst_i)
      por_i && xt1_hf_mode_o |=> ##[0:1] !xt1_enable_o)
      else $error("first crystal runs during power on reset");
   wdt_keep_a: assert property (disable iff (sys_rst_i || por_i || rst_pin_i)
      (wdt_expire_i || wdt_key_viol_i) && xt1_enable_o |=> xt1_enable_o)
      else $error("watchdog stopped first crystal");
endmodule
bind ofc_osc_fault_ctrl ofc_props u_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .por_i(por_i),
   .rst_pin_i(rst_pin_i), .wdt_expire_i(wdt_expire_i), .wdt_key_viol_i(wdt_key_viol_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .pready_o(pready_o), .xt1_enable_o(xt1_enable_o),
   .xt1_hf_mode_o(xt1_hf_mode_o), .xt2_enable_o(xt2_enable_o), .rc_osc_on_o(rc_osc_on_o),
   .rc_bias_on_o(rc_bias_on_o), .power_up_clear_o(power_up_clear_o));

// ==== verification/ofc_xtal_model.sv ====
module ofc_xtal_model
(
   input wire logic en_i,
   input wire logic run_i,
   output logic clk_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // crystal swings only when enabled and not failed, else it freezes
   initial
   begin
      clk_o = 1'b0;
      forever
      begin
         #40;
         if (en_i && run_i)
            clk_o = ~clk_o;
      end
   end
endmodule

// ==== verification/tb_osc_fault_and_rc_clock_gating.sv ====
`include "ofc_map.vh"
module tb_osc_fault_and_rc_clock_gating;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 0, sys_rst_i = 1, por_i = 0, pin = 0, wd = 0, wk = 0, r1 = 1, r2 = 1;
   logic psel_i = 0, penable_i = 0, pwrite_i = 0, err;
   logic [11:0] paddr_i = 0;
   logic [31:0] pwdata_i = 0, rd;
   wire [31:0] prdata_o;
   wire pready_o, pslverr_o, x1e, x1h, x1f, x2e, x2f, rco, rcb, nmi, power_up_clear, k1, k2;
   int n_errors = 0, num_checks = 0;
   ofc_osc_fault_ctrl uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .por_i(por_i), .rst_pin_i(pin),
      .wdt_expire_i(wd), .wdt_key_viol_i(wk), .xt1_clk_i(k1), .xt2_clk_i(k2), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .xt1_enable_o(x1e),
      .xt1_hf_mode_o(x1h), .xt1_fast_start_o(x1f), .xt2_enable_o(x2e),
      .xt2_fast_start_o(x2f), .rc_osc_on_o(rco), .rc_bias_on_o(rcb), .nmi_req_o(nmi),
      .power_up_clear_o(power_up_clear));
   ofc_xtal_model xa (.en_i(x1e), .run_i(r1), .clk_o(k1));
   ofc_xtal_model xb (.en_i(x2e), .run_i(r2), .clk_o(k2));
   initial forever #4 clk_i = ~clk_i;
   // one apb transfer, held until pready is seen
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do
         @(posedge clk_i);
      while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chkb(input logic g, input logic e);
      chk({31'h0, g}, {31'h0, e});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // bounded wait for both fault levels
   task automatic till(input logic v1, input logic v2);
      for (int i = 0; i < 30000 && (x1f !== v1 || x2f !== v2); i++)
         @(posedge clk_i);
   endtask
   // software flag clear, then read back
   task automatic clr(input logic e);
      apb(1'b1, `OFC_FLAG_ADDR, 32'h1);
      apb(1'b0, `OFC_STAT_ADDR, 32'h0);
      chkb(rd[0], e);
   endtask
   task automatic setc(input logic [31:0] c, input logic [31:0] s);
      apb(1'b1, `OFC_CLKSEL_ADDR, s);
      apb(1'b1, `OFC_CTRL_ADDR, c);
      cyc(4);
   endtask
   task automatic t_reset;
      chkb(rco & rcb, 1'b1);
      apb(1'b0, `OFC_DCO_ADDR, 32'h0);
      chk(rd, 32'h0000_0034);
      apb(1'b0, 12'h100, 32'h0);
      chk({err, rd[30:0]}, 32'h8000_0000);
   endtask
   task automatic t_fault;
      apb(1'b1, `OFC_CTRL_ADDR, 32'h0000_0040);
      cyc(3);
      chkb(nmi, 1'b1);
      clr(1'b1);
      till(1'b0, 1'b0);
      chkb(x1f | x2f, 1'b0);
      clr(1'b0);
   endtask
   task automatic t_stop;
      r2 <= 1'b0;
      cyc(11250);
      chkb(x2f, 1'b0);
      till(1'b0, 1'b1);
      chkb(x2f, 1'b1);
      cyc(3);
      chkb(nmi, 1'b1);
      clr(1'b1);
      r2 <= 1'b1;
      cyc(11250);
      chkb(x2f, 1'b1);
      till(1'b0, 1'b0);
      clr(1'b0);
      chkb(nmi, 1'b0);
   endtask
   task automatic t_puc;
      apb(1'b1, `OFC_CTRL_ADDR, 32'h0000_0020);
      for (int i = 0; i < 2; i++)
      begin
         apb(1'b1, `OFC_DCO_ADDR, 32'h0000_1F77);
         apb(1'b0, `OFC_DCO_ADDR, 32'h0);
         chk(rd, 32'h0000_1F77);
         wd <= (i == 0);
         wk <= (i == 1);
         cyc(1);
         wd <= 1'b0;
         wk <= 1'b0;
         cyc(2);
         chkb(x1e & x1h, 1'b1);
         cyc(2);
         apb(1'b0, `OFC_DCO_ADDR, 32'h0);
         chk(rd, 32'h0000_0034);
      end
      pin <= 1'b1;
      cyc(10);
      chkb(x1e, 1'b0);
      chkb(power_up_clear, 1'b1);
      pin <= 1'b0;
      cyc(5);
      por_i <= 1'b1;
      cyc(3);
      chkb(x1e, 1'b0);
      chkb(power_up_clear, 1'b1);
      por_i <= 1'b0;
      cyc(5);
   endtask
   task automatic t_gate;
      setc(32'h0000_0003, 32'h0);
      chkb(rco | ~rcb, 1'b0);
      setc(32'h0000_0007, 32'h0);
      chkb(rcb, 1'b0);
      setc(32'h0000_0004, 32'h0000_0006);
      chkb(rco | rcb, 1'b0);
      setc(32'h0000_0038, 32'h0000_0002);
      chkb(x2e & ~x1e & x1h, 1'b1);
      setc(32'h0000_0018, 32'h0000_0003);
      chkb(x1e & ~x2e, 1'b1);
      setc(32'h0000_0014, 32'h0000_0004);
      chkb(x2e & rcb, 1'b1);
   endtask
   task automatic summarize;
      if (n_errors == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      cyc(20);
      sys_rst_i <= 1'b0;
      cyc(3);
      t_reset();
      t_fault();
      t_stop();
      t_puc();
      t_gate();
      summarize();
   end
   // hang guard
   initial
   begin
      #480000;
      n_errors++;
      summarize();
   end
endmodule
